// ### vdv_top.sv
// Field-2 V-bit generator and write-only display FIFO destination decode.
// Assumes the frame line counter and EAV strobe come from the display timing
// logic on the same clock, and the DMA writer sits in the data memory space.
`timescale 1ns/1ps
module vdv_top
  import vdv_pkg::*;
#(
  parameter int DATA_W     = 32,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  // Configuration register port.
  input  wire logic              cfg_wr_i,
  input  wire logic              cfg_rd_i,
  input  wire logic [7:0]        cfg_addr_i,
  input  wire logic [31:0]       cfg_wdata_i,
  output logic      [31:0]       cfg_rdata_o,
  // Data memory port for the FIFO destination locations.
  input  wire logic              mem_wr_i,
  input  wire logic              mem_rd_i,
  input  wire logic [7:0]        mem_addr_i,
  input  wire logic [DATA_W-1:0] mem_wdata_i,
  output logic      [DATA_W-1:0] mem_rdata_o,
  // Display timing side.
  input  wire logic [1:0]        display_mode_i,
  input  wire logic              eav_strobe_i,
  input  wire logic [11:0]       frame_line_counter_i,
  output logic                   field2_vbit_o,
  // Pixel pull side, one per FIFO.
  input  wire logic [2:0]        fifo_pull_i,
  output logic      [DATA_W-1:0] luma_data_o,
  output logic      [DATA_W-1:0] blue_chroma_data_o,
  output logic      [DATA_W-1:0] red_chroma_data_o,
  output logic      [2:0]        fifo_full_o,
  output logic      [2:0]        fifo_empty_o,
  // Per-FIFO DMA request events.
  output logic                   luma_dma_request_o,
  output logic                   blue_chroma_dma_request_o,
  output logic                   red_chroma_dma_request_o
);

  // --------------------------------------------------------------------------
  // Address decode helpers
  // --------------------------------------------------------------------------
  // True when a configuration access targets the field-2 V-bit register.
  function automatic logic hits_vbit2(input logic [7:0] addr);
    return addr == VDV_VBIT2_OFS;
  endfunction

  // True when a data-memory write lands on the given destination offset.
  function automatic logic hits_dest(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  // --------------------------------------------------------------------------
  // Field-2 V-bit register
  // --------------------------------------------------------------------------
  logic [11:0] set_line_q, set_line_d, clr_line_q, clr_line_d;
  logic [31:0] cfg_rdata_q, cfg_rdata_d;

  always_comb begin
    set_line_d  = set_line_q;
    clr_line_d  = clr_line_q;
    // Read data is zero outside a read so a stale word is never taken as fresh.
    cfg_rdata_d = '0;
    if (cfg_wr_i && hits_vbit2(cfg_addr_i)) begin
      // Only the two line fields are stored; reserved bits are dropped.
      set_line_d = cfg_wdata_i[VDV_SET_LSB +: VDV_LINE_W];
      clr_line_d = cfg_wdata_i[VDV_CLR_LSB +: VDV_LINE_W];
    end
    if (cfg_rd_i && hits_vbit2(cfg_addr_i)) begin
      cfg_rdata_d[VDV_SET_LSB +: VDV_LINE_W] = set_line_q;
      cfg_rdata_d[VDV_CLR_LSB +: VDV_LINE_W] = clr_line_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      set_line_q  <= VDV_LINE_RST;
      clr_line_q  <= VDV_LINE_RST;
      cfg_rdata_q <= '0;
    end else begin
      set_line_q  <= set_line_d;
      clr_line_q  <= clr_line_d;
      cfg_rdata_q <= cfg_rdata_d;
    end
  end

  assign cfg_rdata_o = cfg_rdata_q;

  // --------------------------------------------------------------------------
  // V-bit generation
  // --------------------------------------------------------------------------
  logic vbit_q, vbit_d;
  logic is_raw;

  always_comb begin
    is_raw = (display_mode_i == VDV_MODE_RAW);
    vbit_d = vbit_q;
    // Set is tested first, so equal settings leave V at 1; raw mode leaves the
    // bit untouched because it has no meaning there.
    // Evaluated only on the line-start EAV; held through SAV codes.
    if (eav_strobe_i && !is_raw) begin
      if (frame_line_counter_i == set_line_q) begin
        vbit_d = 1'b1;
      end else if (frame_line_counter_i == clr_line_q) begin
        vbit_d = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      vbit_q <= 1'b0;
    end else begin
      vbit_q <= vbit_d;
    end
  end

  assign field2_vbit_o = vbit_q;

  // --------------------------------------------------------------------------
  // FIFO destination decode
  // --------------------------------------------------------------------------
  logic [2:0] push;
  logic [2:0] full_w, empty_w;
  logic [2:0] req_q, req_d;
  logic [DATA_W-1:0] rdata [3];

  // Destinations live on the data memory port only.
  always_comb begin
    push = '0;
    if (mem_wr_i) begin
      // A and B copies alias at one offset.
      push[0] = hits_dest(mem_addr_i, VDV_LUMA_DEST_OFS);
      // Chroma locations are ignored in raw mode.
      push[1] = hits_dest(mem_addr_i, VDV_BLUE_DEST_OFS) && !is_raw;
      push[2] = hits_dest(mem_addr_i, VDV_RED_DEST_OFS) && !is_raw;
    end
    // Each FIFO requests refills while it has room, except the chroma FIFOs in raw mode.
    // The request follows fullness one clock late, so a writer that streams
    // on the request alone may land one extra write, which a full FIFO drops.
    req_d = ~full_w;
    if (is_raw) begin
      req_d[2:1] = '0;
    end
  end

  // One FIFO per component: index 0 luma, 1 blue chroma, 2 red chroma.
  for (genvar g = 0; g < 3; g++) begin : g_fifo
    vdv_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
    ) u_fifo (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .wr_en_i   (push[g]),
      .wr_data_i (mem_wdata_i),
      .rd_en_i   (fifo_pull_i[g]),
      .rd_data_o (rdata[g]),
      .full_o    (full_w[g]),
      .empty_o   (empty_w[g])
    );
  end

  // --------------------------------------------------------------------------
  // Status and read-data registers
  // --------------------------------------------------------------------------
  logic [2:0]        full_q, empty_q;
  logic [DATA_W-1:0] mem_rdata_q, mem_rdata_d;

  // Destination reads return a fixed value and touch no FIFO state.
  always_comb begin
    mem_rdata_d = VDV_ARB_RDATA[DATA_W-1:0];
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      req_q       <= '0;
      full_q      <= '0;
      empty_q     <= '1;
      mem_rdata_q <= VDV_ARB_RDATA[DATA_W-1:0];
    end else begin
      req_q       <= req_d;
      full_q      <= full_w;
      empty_q     <= empty_w;
      mem_rdata_q <= mem_rdata_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign mem_rdata_o               = mem_rdata_q;
  assign luma_data_o               = rdata[0];
  assign blue_chroma_data_o        = rdata[1];
  assign red_chroma_data_o         = rdata[2];
  assign fifo_full_o               = full_q;
  assign fifo_empty_o              = empty_q;
  assign luma_dma_request_o        = req_q[0];
  assign blue_chroma_dma_request_o = req_q[1];
  assign red_chroma_dma_request_o  = req_q[2];

endmodule

// ### vdv_pkg.sv
// Package for the field-2 V-bit and display FIFO destination block.
// Assumes a single 100 MHz display clock and a synchronous active-low reset.
package vdv_pkg;

  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  localparam logic [7:0]  VDV_LUMA_DEST_OFS  = 8'h80;
  localparam logic [7:0]  VDV_BLUE_DEST_OFS  = 8'ha0;
  localparam logic [7:0]  VDV_RED_DEST_OFS   = 8'hc0;
  localparam logic [7:0]  VDV_VBIT2_OFS      = 8'h00;

  // --------------------------------------------------------------------------
  // Field layout of the field-2 V-bit register
  // --------------------------------------------------------------------------
  localparam int          VDV_LINE_W         = 12;
  localparam int          VDV_CLR_LSB        = 16;
  localparam int          VDV_SET_LSB        = 0;
  localparam logic [11:0] VDV_LINE_RST       = 12'h000;
  localparam logic [31:0] VDV_ARB_RDATA      = 32'h0000_0000;

  // --------------------------------------------------------------------------
  // Display modes
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    VDV_MODE_BT656 = 2'h0,
    VDV_MODE_YC    = 2'h1,
    VDV_MODE_RAW   = 2'h3
  } vdv_mode_t;

endpackage

// ### vdv_fifo.sv
// Display FIFO memory with registered read data.
// Ignores writes while full and reads while empty, so neither side need honour the flags.
`timescale 1ns/1ps
module vdv_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             wr_en_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic             rd_en_i,
  output logic      [WIDTH-1:0] rd_data_o,
  output logic                  full_o,
  output logic                  empty_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
  logic [WIDTH-1:0] rd_q, rd_d;
  logic             do_wr, do_rd;

  always_comb begin
    do_wr = wr_en_i && !full_o;
    do_rd = rd_en_i && !empty_o;
    wp_d  = do_wr ? wp_q + 1'b1 : wp_q;
    rp_d  = do_rd ? rp_q + 1'b1 : rp_q;
    rd_d  = do_rd ? mem_q[rp_q[AW-1:0]] : rd_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (do_wr) begin
      mem_q[wp_q[AW-1:0]] <= wr_data_i;
    end
    if (!rst_n_i) begin
      wp_q <= '0;
      rp_q <= '0;
      rd_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      rd_q <= rd_d;
    end
  end

  assign rd_data_o = rd_q;
  assign empty_o   = (wp_q == rp_q);
  assign full_o    = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
endmodule

// ### vdv_top_props.sv
// Assertions on the vdv_top ports.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
module vdv_top_props
  import vdv_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic        cfg_wr_i,
  input wire logic        cfg_rd_i,
  input wire logic [7:0]  cfg_addr_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic        mem_wr_i,
  input wire logic [7:0]  mem_addr_i,
  input wire logic [1:0]  display_mode_i,
  input wire logic        eav_strobe_i,
  input wire logic [11:0] frame_line_counter_i,
  input wire logic        field2_vbit_o,
  input wire logic [2:0]  fifo_pull_i,
  input wire logic [2:0]  fifo_full_o,
  input wire logic [2:0]  fifo_empty_o,
  input wire logic        blue_chroma_dma_request_o,
  input wire logic        red_chroma_dma_request_o,
  input wire logic        luma_dma_request_o
);
  logic [11:0] set_q;
  logic [11:0] clr_q;
  logic        hit_set;
  logic        hit_clr;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  assign hit_set = eav_strobe_i && display_mode_i != VDV_MODE_RAW && frame_line_counter_i == set_q;
  assign hit_clr = eav_strobe_i && display_mode_i != VDV_MODE_RAW && frame_line_counter_i == clr_q;
  // Shadow copy of the line settings, updated on the same edge as the design.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      set_q <= VDV_LINE_RST;
      clr_q <= VDV_LINE_RST;
    end else if (cfg_wr_i && cfg_addr_i == VDV_VBIT2_OFS) begin
      set_q <= cfg_wdata_i[11:0];
      clr_q <= cfg_wdata_i[27:16];
    end
  end
  property p_set; hit_set |=> field2_vbit_o; endproperty
  a_set: assert property (p_set) else $error("vbit not set");
  property p_clr; hit_clr && !hit_set |=> !field2_vbit_o; endproperty
  a_clr: assert property (p_clr) else $error("vbit not cleared");
  property p_hold; !(hit_set || hit_clr) |=> $stable(field2_vbit_o); endproperty
  a_hold: assert property (p_hold) else $error("vbit moved");
  property p_rd; cfg_rd_i && !cfg_wr_i && cfg_addr_i == VDV_VBIT2_OFS
    |=> cfg_rdata_o == {4'h0, clr_q, 4'h0, set_q}; endproperty
  a_rd: assert property (p_rd) else $error("bad readback");
  property p_rdz; cfg_rd_i && cfg_addr_i != VDV_VBIT2_OFS |=> cfg_rdata_o == 32'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("unmapped read not zero");
  property p_quiet; (!mem_wr_i && fifo_pull_i == 3'h0) [*3] |=> $stable({fifo_full_o, fifo_empty_o});
  endproperty
  a_quiet: assert property (p_quiet) else $error("flags moved");
  property p_raw; display_mode_i == VDV_MODE_RAW
    |=> !blue_chroma_dma_request_o && !red_chroma_dma_request_o; endproperty
  a_raw: assert property (p_raw) else $error("chroma request in raw");
  property p_full; fifo_full_o[0] [*2] |-> !luma_dma_request_o; endproperty
  a_full: assert property (p_full) else $error("request while full");
  property p_push; mem_wr_i && mem_addr_i == VDV_LUMA_DEST_OFS && fifo_empty_o[0] && !fifo_pull_i[0]
    |=> ##1 !fifo_empty_o[0]; endproperty
  a_push: assert property (p_push) else $error("luma push lost");
  c_set: cover property (hit_set);
  c_full: cover property (fifo_full_o == 3'h7);
  c_raw: cover property (eav_strobe_i && display_mode_i == VDV_MODE_RAW);
endmodule
bind vdv_top vdv_top_props u_vdv_top_props (.*);

// ### vdv_dma_model.sv
// DMA writer that refills the display FIFOs while their requests are high.
// Assumes the vdv_top request outputs and data-memory write port, one clock.
`timescale 1ns/1ps
module vdv_dma_model (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        run_i,
  input  wire logic        slow_i,
  input  wire logic [2:0]  req_i,
  output logic             wr_o,
  output logic      [7:0]  addr_o,
  output logic      [31:0] data_o
);
  logic [23:0] seq_q;
  // Idle cycles invert the bus every clock, so the last written address and data show again on every second idle cycle.
  always_ff @(posedge sys_clk_i) begin
    wr_o <= 1'b0;
    addr_o <= ~addr_o;
    data_o <= ~data_o;
    if (!rst_n_i) begin
      seq_q <= 24'h0;
      addr_o <= 8'h00;
      data_o <= 32'h0;
    end else if (run_i && !(slow_i && wr_o) && req_i != 3'h0) begin
      wr_o <= 1'b1;
      addr_o <= req_i[0] ? 8'h80 : (req_i[1] ? 8'ha0 : 8'hc0);
      data_o <= {8'h5a, seq_q};
      seq_q <= seq_q + 24'h1;
    end
  end
endmodule

// ### testbench.sv
// Self-checking bench for vdv_top with the DMA writer model.
// Assumes the package, design, checker and model files are compiled first.
`timescale 1ns/1ps
module testbench;
  import vdv_pkg::*;
  logic        clk, rst_n, cfg_wr, cfg_rd, mem_rd, eav, run, slow, vbit, dma_wr, poke;
  logic [7:0]  cfg_addr, dma_addr;
  logic [31:0] cfg_wdata, cfg_rdata, dma_data, mem_rdata, luma_d, blue_d, red_d;
  logic [1:0]  mode;
  logic [11:0] line;
  logic [2:0]  pull, full, empty, req;
  int          fails = 0;
  int          checks = 0;
  vdv_top u_vdv_top (.sys_clk_i(clk), .rst_n_i(rst_n), .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd),
    .cfg_addr_i(cfg_addr), .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(cfg_rdata),
    .mem_wr_i(dma_wr | poke), .mem_rd_i(mem_rd), .mem_wdata_i(dma_data),
    .mem_addr_i(mem_rd ? VDV_LUMA_DEST_OFS : (poke ? VDV_BLUE_DEST_OFS : dma_addr)),
    .mem_rdata_o(mem_rdata), .display_mode_i(mode), .eav_strobe_i(eav),
    .frame_line_counter_i(line), .field2_vbit_o(vbit), .fifo_pull_i(pull),
    .luma_data_o(luma_d), .blue_chroma_data_o(blue_d), .red_chroma_data_o(red_d),
    .fifo_full_o(full), .fifo_empty_o(empty), .luma_dma_request_o(req[0]),
    .blue_chroma_dma_request_o(req[1]), .red_chroma_dma_request_o(req[2]));
  vdv_dma_model u_vdv_dma_model (.sys_clk_i(clk), .rst_n_i(rst_n), .run_i(run), .slow_i(slow),
    .req_i(req), .wr_o(dma_wr), .addr_o(dma_addr), .data_o(dma_data));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cfg_access(input logic wr, input logic [7:0] a, input logic [31:0] d);
    cfg_wr = wr;
    cfg_rd = !wr;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk);
    {cfg_wr, cfg_rd} = 2'b00;
    if (!wr) check("cfg_rdata", cfg_rdata, d);
    @(negedge clk);
  endtask
  task automatic line_start(input logic [11:0] n, input logic exp);
    eav = 1'b1;
    line = n;
    @(negedge clk);
    eav = 1'b0;
    check("vbit", {31'h0, vbit}, {31'h0, exp});
    @(negedge clk);
  endtask
  task automatic wait_full(input logic [2:0] want);
    for (int n = 0; n < 400 && full !== want; n++) @(negedge clk);
    check("full", {29'h0, full}, {29'h0, want});
    if (full !== want) close_out();
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst_n, cfg_wr, cfg_rd, mem_rd, eav, run, slow, poke, pull, line, cfg_addr, cfg_wdata} = '0;
    mode = VDV_MODE_BT656;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    check("empty", {29'h0, empty}, 32'h7);
    cfg_access(1'b0, VDV_VBIT2_OFS, 32'h0);
    cfg_access(1'b1, VDV_VBIT2_OFS, 32'hffff_ffff);
    cfg_access(1'b0, VDV_VBIT2_OFS, 32'h0fff_0fff);
    cfg_access(1'b0, VDV_LUMA_DEST_OFS, 32'h0);
    cfg_access(1'b1, VDV_VBIT2_OFS, 32'h0005_0003);
    for (int m = 0; m < 2; m++) begin
      mode = 2'(m);
      line_start(12'h003, 1'b1);
      line_start(12'h004, 1'b1);
      line = 12'h005;
      @(negedge clk);
      check("vbit", {31'h0, vbit}, 32'h1);
      line_start(12'h005, 1'b0);
    end
    mode = VDV_MODE_RAW;
    line_start(12'h003, 1'b0);
    mode = VDV_MODE_BT656;
    // Field-2 lines of a 525-line frame, clear of the field-1 range.
    cfg_access(1'b1, VDV_VBIT2_OFS, 32'h011b_0108);
    line_start(12'h108, 1'b1);
    line_start(12'h11b, 1'b0);
    // Progressive: both lines above the frame height never fire.
    cfg_access(1'b1, VDV_VBIT2_OFS, 32'h020f_020e);
    line_start(12'h108, 1'b0);
    line_start(12'h20c, 1'b0);
    check("req", {29'h0, req}, 32'h7);
    {slow, run} = 2'b11;
    wait_full(3'h7);
    run = 1'b0;
    mem_rd = 1'b1;
    repeat (2) @(negedge clk);
    mem_rd = 1'b0;
    check("mem_rdata", mem_rdata, VDV_ARB_RDATA);
    check("req", {29'h0, req}, 32'h0);
    check("full", {29'h0, full}, 32'h7);
    pull = 3'h1;
    @(negedge clk);
    pull = 3'h7;
    check("luma", luma_d, 32'h5a00_0000);
    @(negedge clk);
    // One write is dropped as luma fills and one as blue fills, so blue starts at 17 and red at 34.
    check("luma", luma_d, 32'h5a00_0001);
    check("blue", blue_d, 32'h5a00_0011);
    check("red", red_d, 32'h5a00_0022);
    repeat (39) @(negedge clk);
    pull = 3'h0;
    @(negedge clk);
    check("empty", {29'h0, empty}, 32'h7);
    mode = VDV_MODE_RAW;
    @(negedge clk);
    check("req", {29'h0, req}, 32'h1);
    {slow, run} = 2'b01;
    wait_full(3'h1);
    run = 1'b0;
    @(negedge clk);
    check("empty", {29'h0, empty}, 32'h6);
    poke = 1'b1;
    @(negedge clk);
    poke = 1'b0;
    repeat (2) @(negedge clk);
    check("empty", {29'h0, empty}, 32'h6);
    mode = VDV_MODE_BT656;
    poke = 1'b1;
    @(negedge clk);
    poke = 1'b0;
    repeat (2) @(negedge clk);
    check("empty", {29'h0, empty}, 32'h4);
    close_out();
  end
endmodule
